// ==== rtl/eis_irq_status.sv ====
// sticky interrupt status bits for receive-disabled, phy interrupt and
// data-port done, with mask and a level interrupt output.
// assumes receive-disabled flags and data-port pulse are on core_clk;
// the phy interrupt pin is asynchronous and active low.
//
// Summary of operation
// - bit 18 sets once the rx fifo or mac receiver has finished disabling, resets to zero.
// - the receive-disabled source is a level, so bit 18 re-sets while either flag holds.
// - bit 17 sets when the external phy pulls its active-low interrupt pin.
// - the phy condition stays until the phy releases its pin; clearing bit 17 alone does not end it.
// - bit 16 sets when a requested data port operation has finished.
// - the data-port source is a one-cycle pulse, held in bit 16 until software clears it.
`timescale 1ns/1ns
`default_nettype none
module eis_irq_status (
	input  wire logic                       core_clk,
	input  wire logic                       sys_rst,
	input  wire logic [eis_pkg::ADDR_W-1:0] regAddr,
	input  wire logic [eis_pkg::DATA_W-1:0] regWrData,
	input  wire logic                       regWrStrobe,
	input  wire logic                       regRdStrobe,
	output var  logic [eis_pkg::DATA_W-1:0] regRdData,
	input  wire logic                       fifoRxControlDisabled,
	input  wire logic                       macReceiveControlDisabled,
	input  wire logic                       extPhyIrqPin_n,
	input  wire logic                       dataPortDonePulse,
	output var  logic                       rxPathDisabledIrq,
	output var  logic                       extPhyIrq,
	output var  logic                       dataPortDoneIrq,
	output var  logic                       irqOut
);
	import eis_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [NUM_SRC-1:0] status;
		logic [NUM_SRC-1:0] mask;
		logic [DATA_W-1:0]  rdData;
		logic               irq;
	} eis_state_type;

	eis_state_type cur_ff;
	eis_state_type nxt_cur;

	logic               phyPinStable_n;
	logic [NUM_SRC-1:0] srcSet;
	logic [NUM_SRC-1:0] srcClr;
	logic [NUM_SRC-1:0] wrOnes;
	logic               hitStatus;
	logic               hitMask;

	////////////////////////////////////////////////////////////////////////////
	eis_pin_sync u_phy_sync (
		.core_clk  (core_clk),
		.sys_rst   (sys_rst),
		.pinIn     (extPhyIrqPin_n),
		.pinStable (phyPinStable_n)
	);

	////////////////////////////////////////////////////////////////////////////
	assign hitStatus = (regAddr == OFS_IRQ_STATUS);
	assign hitMask   = (regAddr == OFS_IRQ_MASK);
	assign wrOnes    = regWrData[SRC_LSB +: NUM_SRC];

	// set sources, index 0 is bit 16
	always_comb begin
		srcSet    = '0;
		srcSet[0] = dataPortDonePulse;
		// pin low means the phy still holds its interrupt
		srcSet[1] = ~phyPinStable_n;
		srcSet[2] = fifoRxControlDisabled | macReceiveControlDisabled;
	end

	// clears come from a one-write or a read of the status word
	always_comb begin
		srcClr = '0;
		if (regWrStrobe && hitStatus) begin
			srcClr = wrOnes;
		end else if (regRdStrobe && hitStatus) begin
			srcClr = '1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		nxt_cur = cur_ff;
		// set beats clear so an event in the clearing cycle is kept
		nxt_cur.status = (cur_ff.status & ~srcClr) | srcSet;
		if (regWrStrobe && hitMask) begin
			nxt_cur.mask = wrOnes;
		end
		nxt_cur.rdData = '0;
		if (regRdStrobe) begin
			if (hitStatus) begin
				nxt_cur.rdData[SRC_LSB +: NUM_SRC] = cur_ff.status;
			end else if (hitMask) begin
				nxt_cur.rdData[SRC_LSB +: NUM_SRC] = cur_ff.mask;
			end
		end
		// registered from the next status and mask, so irq changes in the same cycle as the status
		nxt_cur.irq = |(nxt_cur.status & nxt_cur.mask);
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cur_ff.status <= RST_STATUS;
			cur_ff.mask   <= RST_MASK;
			cur_ff.rdData <= RST_RDATA;
			cur_ff.irq    <= 1'b0;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign regRdData         = cur_ff.rdData;
	assign dataPortDoneIrq   = cur_ff.status[0];
	assign extPhyIrq         = cur_ff.status[1];
	assign rxPathDisabledIrq = cur_ff.status[2];
	assign irqOut            = cur_ff.irq;

endmodule : eis_irq_status
`default_nettype wire

// ==== rtl/eis_pin_sync.sv ====
// three-stage synchroniser with agreement filter for one pin.
// assumes an asynchronous pin; output changes only when stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module eis_pin_sync (
	input  wire logic core_clk,
	input  wire logic sys_rst,
	input  wire logic pinIn,
	output var  logic pinStable
);
	import eis_pkg::*;

	typedef struct packed {
		logic [eis_pkg::SYNC_DEPTH-1:0] stage;
		logic                           stable;
	} eis_sync_state_type;

	eis_sync_state_type cur_ff;
	eis_sync_state_type nxt_cur;

	always_comb begin
		nxt_cur = cur_ff;
		// stage 0 feeds stage 1 only; nothing else looks at it
		nxt_cur.stage = {cur_ff.stage[SYNC_DEPTH-2:0], pinIn};
		if (cur_ff.stage[1] == cur_ff.stage[2]) begin
			nxt_cur.stable = cur_ff.stage[2];
		end
	end

	always_ff @(posedge core_clk or posedge sys_rst) begin
		if (sys_rst) begin
			cur_ff.stage  <= {SYNC_DEPTH{RST_PIN_N}};
			cur_ff.stable <= RST_PIN_N;
		end else begin
			cur_ff <= nxt_cur;
		end
	end

	assign pinStable = cur_ff.stable;

endmodule : eis_pin_sync
`default_nettype wire

// ==== rtl/eis_pkg.sv ====
// constants for the ethernet interrupt status bits block.
// assumes a 32-bit register port and a 25 MHz core clock.
package eis_pkg;

	localparam int unsigned ADDR_W = 8;
	localparam int unsigned DATA_W = 32;

	// register offsets (byte addresses)
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h00;
	localparam logic [7:0] OFS_IRQ_MASK   = 8'h04;

	// field positions inside status and mask
	localparam int unsigned BIT_DATA_PORT_DONE = 16;
	localparam int unsigned BIT_EXT_PHY        = 17;
	localparam int unsigned BIT_RX_PATH_DIS    = 18;
	localparam int unsigned NUM_SRC            = 3;
	localparam int unsigned SRC_LSB            = BIT_DATA_PORT_DONE;

	// reset values
	localparam logic [NUM_SRC-1:0] RST_STATUS = 3'h0;
	localparam logic [NUM_SRC-1:0] RST_MASK   = 3'h0;
	localparam logic [DATA_W-1:0]  RST_RDATA  = 32'h0000_0000;
	localparam logic               RST_PIN_N  = 1'h1;

	// synchroniser depth for the phy interrupt pin
	localparam int unsigned SYNC_DEPTH = 3;

endpackage : eis_pkg

// ==== verification/eis_irq_monitor.sv ====
// checker for the status bits block.
// assumes binding to eis_irq_status.
`timescale 1ns/1ns
`default_nettype none
module eis_irq_monitor (
	input wire logic core_clk, sys_rst, regWrStrobe, regRdStrobe,
	input wire logic [7:0] regAddr,
	input wire logic [31:0] regWrData,
	input wire logic fifoRxControlDisabled, macReceiveControlDisabled,
	input wire logic extPhyIrqPin_n, dataPortDonePulse,
	input wire logic rxPathDisabledIrq, extPhyIrq, dataPortDoneIrq,
	input wire logic irqOut,
	input wire logic [31:0] regRdData
);
	import eis_pkg::*;
	logic st, rx, c16, c17;
	assign st = regAddr == OFS_IRQ_STATUS;
	assign rx = fifoRxControlDisabled | macReceiveControlDisabled;
	assign c16 = st & (regRdStrobe | regWrStrobe & regWrData[16]);
	assign c17 = st & (regRdStrobe | regWrStrobe & regWrData[17]);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	AST_RX_SET: assert property (rx |=> rxPathDisabledIrq)
		else $error("rx bit not set");
	AST_RX_QUIET: assert property (!rxPathDisabledIrq && !rx |=> !rxPathDisabledIrq)
		else $error("rx bit without source");
	// sync chain needs about four edges
	AST_PHY_SET: assert property (!extPhyIrqPin_n [*6] |-> extPhyIrq)
		else $error("phy bit not set");
	AST_PHY_HOLD: assert property (extPhyIrq && !c17 |=> extPhyIrq)
		else $error("phy bit lost");
	AST_DP_SET: assert property (dataPortDonePulse |=> dataPortDoneIrq)
		else $error("done bit not set");
	AST_DP_HOLD: assert property (dataPortDoneIrq && !c16 |=> dataPortDoneIrq)
		else $error("done bit lost");
	AST_DP_CLR: assert property (c16 && !dataPortDonePulse |=> !dataPortDoneIrq)
		else $error("done bit not cleared");
	// no status bit set means no interrupt, whatever the mask holds
	AST_IRQ_QUIET: assert property (!rxPathDisabledIrq && !extPhyIrq && !dataPortDoneIrq |-> !irqOut)
		else $error("interrupt without status");
	AST_RD_IDLE: assert property (!regRdStrobe |=> regRdData == 32'h0000_0000)
		else $error("read data outside read");
endmodule : eis_irq_monitor
bind eis_irq_status eis_irq_monitor mon (.*);
`default_nettype wire

// ==== verification/eis_phy_model.sv ====
// phy interrupt output, driven low while an event is pending and high otherwise.
// assumes the bench raises and clears the phy's own event.
`timescale 1ns/1ns
`default_nettype none
module eis_phy_model (
	input  wire logic core_clk,
	input  wire logic raise,
	input  wire logic clear,
	output var  logic extPhyIrqPin_n
);
	logic pend_ff = 1'h0;
	// held until cleared inside the phy
	always_ff @(posedge core_clk) if (raise | clear) pend_ff <= raise;
	assign extPhyIrqPin_n = !pend_ff;
endmodule : eis_phy_model
`default_nettype wire

// ==== verification/tb_top.sv ====
// bench for the status bits block.
// assumes the phy model drives the pin.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin failures++; \
	$display("BAD %0t %h %h", $time, a, b); end end
module tb_top;
	import eis_pkg::*;
	logic core_clk = 0, sys_rst = 1, wr = 0, rd = 0, fifo = 0, mac = 0, dp = 0, up = 0, dn = 0;
	logic [7:0] ad = 0;
	logic [31:0] wd = 0, rdat;
	logic pin, rxI, phyI, dpI, irq;
	int failures = 0, n_tests = 0, cyc = 0;
	eis_phy_model phy (.core_clk, .raise(up), .clear(dn), .extPhyIrqPin_n(pin));
	eis_irq_status uut (.core_clk, .sys_rst, .regAddr(ad), .regWrData(wd), .regWrStrobe(wr),
		.regRdStrobe(rd), .regRdData(rdat), .fifoRxControlDisabled(fifo),
		.macReceiveControlDisabled(mac), .extPhyIrqPin_n(pin), .dataPortDonePulse(dp),
		.rxPathDisabledIrq(rxI), .extPhyIrq(phyI), .dataPortDoneIrq(dpI), .irqOut(irq));
	initial forever #20 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc++;
		if (cyc > 400) begin failures++; finish_test(); end
	end
	task automatic finish_test();
		if (failures == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : finish_test
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk) begin wr <= w; rd <= !w; ad <= a; wd <= d; end
		@(posedge core_clk) begin wr <= 0; rd <= 0; end
		#1;
	endtask : acc
	task automatic s_rx();
		@(posedge core_clk) fifo <= 1;
		@(posedge core_clk) begin fifo <= 0; mac <= 1; end
		#1 `CHK({rxI, irq}, 2'h2)
		acc(1, OFS_IRQ_STATUS, 32'h0004_0000);
		`CHK(rxI, 1'h1)
		@(posedge core_clk) mac <= 0;
		acc(1, OFS_IRQ_STATUS, 32'h0004_0000);
		`CHK(rxI, 1'h0)
	endtask : s_rx
	task automatic s_phy();
		@(posedge core_clk) up <= 1;
		@(posedge core_clk) up <= 0;
		repeat (6) @(posedge core_clk);
		#1 `CHK(phyI, 1'h1)
		acc(1, OFS_IRQ_STATUS, 32'h0002_0000);
		`CHK(phyI, 1'h1)
		@(posedge core_clk) dn <= 1;
		@(posedge core_clk) dn <= 0;
		repeat (6) @(posedge core_clk);
		acc(1, OFS_IRQ_STATUS, 32'h0002_0000);
		`CHK(phyI, 1'h0)
	endtask : s_phy
	task automatic s_dp();
		acc(1, OFS_IRQ_MASK, 32'h0001_0000);
		@(posedge core_clk) dp <= 1;
		@(posedge core_clk) dp <= 0;
		#1 `CHK({dpI, irq}, 2'h3)
		acc(1, OFS_IRQ_STATUS, 0);
		`CHK(dpI, 1'h1)
		acc(0, 8'h08, 0);
		`CHK(rdat, 32'h0000_0000)
		acc(0, OFS_IRQ_MASK, 0);
		`CHK(rdat, 32'h0001_0000)
		acc(0, OFS_IRQ_STATUS, 0);
		`CHK(rdat, 32'h0001_0000)
		`CHK({dpI, irq}, 2'h0)
	endtask : s_dp
	initial begin
		repeat (10) @(posedge core_clk);
		sys_rst <= 0;
		#1 `CHK({rxI, phyI, dpI, irq}, 4'h0)
		s_rx();
		s_phy();
		s_dp();
		finish_test();
	end
endmodule : tb_top
`default_nettype wire
